// File: design/nvs_host_ctrl.sv
// nvs_host_ctrl: host side controller for an asynchronous nonvolatile sram port
// assumes device pins are synchronous to clk_sys_i and a pull-up on the save/busy wire
//
// Operation
// [RULE1] software command steps by chip-select controlled reads
// [RULE2] six command addresses read in fixed order
// [RULE3] write strobe held high during command reads
// [RULE4] sixth command read data is discarded
// [RULE5] each command read lasts one initiation cycle
// [RULE6] busy released quickly when nothing to save
// [RULE7] save request pulse held low long enough
// [RULE8] device acts within processing time of command
// [RULE9] port locked out while save or restore runs
// [RULE10] save/busy pin released during normal access
// [RULE11] strobe combinations select read, write, idle
// [RULE12] read lanes follow active-low byte enables
// [RULE13] write lanes follow active-low byte enables
// [RULE14] no access issued during save or restore
// [RULE15] save skipped if nothing written since
// [RULE16] no write started after save request
// [RULE17] restore lockout lasts full restore time
// [RULE18] device holds save/busy low while saving
`timescale 1ns/10ps
`default_nettype none

module nvs_host_ctrl
  import nvs_pkg::*;
#(
  parameter int unsigned SS_WAIT     = SS_CYC,      // command processing wait
  parameter int unsigned STORE_WAIT  = STORE_CYC,   // save lockout, long
  parameter int unsigned RECALL_WAIT = RECALL_CYC,  // restore lockout
  parameter logic [AW-1:0] SEQ_STORE  [SEQ_LEN] = '{20'h00001, 20'h00002, 20'h00003,
                                                    20'h00004, 20'h00005, 20'h00006},
  parameter logic [AW-1:0] SEQ_RECALL [SEQ_LEN] = '{20'h00001, 20'h00002, 20'h00003,
                                                    20'h00004, 20'h00005, 20'h00007}
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          resetn_i,
  // user command port
  input  wire logic          req_i,
  input  wire nvs_op_t       op_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [1:0]    be_n_i,
  output logic               ready_o,
  output logic               done_o,
  output logic [DW-1:0]      rdata_o,
  output logic               save_skipped_o,
  // device strobes and address
  output logic [AW-1:0]      mem_addr_o,
  output logic               chip_sel_n_o,
  output logic               write_en_n_o,
  output logic               out_en_n_o,
  output logic               upper_byte_enable_n_o,
  output logic               lower_byte_enable_n_o,
  // device data bus, three signals
  input  wire logic [DW-1:0] dq_i,
  output logic [DW-1:0]      dq_o,
  output logic               dq_oe_o,
  // save request / busy wire, three signals
  input  wire logic          hw_save_busy_n_i,
  output logic               hw_save_busy_n_o,
  output logic               hw_save_busy_n_oe_o
);

  // one-hot sequencer states
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,  // waiting for a request
    ST_ACC    = 8'h02,  // plain read or write strobe phase
    ST_GAP    = 8'h04,  // strobes high between accesses
    ST_SEQ    = 8'h08,  // command read strobe phase
    ST_SEQGAP = 8'h10,  // strobes high between command reads
    ST_HPULSE = 8'h20,  // driving the save request low
    ST_HWAIT  = 8'h40,  // watching for busy after the request
    ST_LOCK   = 8'h80   // device busy, port locked out
  } nvs_state_t;

  // registered state
  nvs_state_t    state_ff,  nxt_state;
  logic [CW-1:0] cnt_ff,    nxt_cnt;      // wait counter
  logic [2:0]    step_ff,   nxt_step;     // command read index
  nvs_op_t       op_ff,     nxt_op;       // op in flight
  logic          hbusy_ff,  nxt_hbusy;    // busy seen after save request
  logic [AW-1:0] addr_ff,   nxt_addr;
  logic [DW-1:0] wdata_ff,  nxt_wdata;
  logic [DW-1:0] rdata_ff,  nxt_rdata;
  logic [1:0]    be_n_ff,   nxt_be_n;
  logic          ce_n_ff,   nxt_ce_n;
  logic          we_n_ff,   nxt_we_n;
  logic          oe_n_ff,   nxt_oe_n;
  logic          dq_oe_ff,  nxt_dq_oe;
  logic          hsb_oe_ff, nxt_hsb_oe;
  logic          done_ff,   nxt_done;
  logic          skip_ff,   nxt_skip;

  // command address for a step; the last read differs between save and restore
  function automatic logic [AW-1:0] seq_addr(input nvs_op_t op, input logic [2:0] step);
    return (op == OP_RECALL) ? SEQ_RECALL[step] : SEQ_STORE[step];
  endfunction

  // keep only the lanes whose enable is low, others read as zero
  function automatic logic [DW-1:0] lane_mask(input logic [DW-1:0] d, input logic [1:0] be_n);
    return {be_n[1] ? 8'h00 : d[15:8], be_n[0] ? 8'h00 : d[7:0]};
  endfunction

  // next-state and pin computation
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_step   = step_ff;
    nxt_op     = op_ff;
    nxt_hbusy  = hbusy_ff;
    nxt_addr   = addr_ff;
    nxt_wdata  = wdata_ff;
    nxt_rdata  = rdata_ff;
    nxt_be_n   = be_n_ff;
    nxt_ce_n   = ce_n_ff;
    nxt_we_n   = we_n_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_dq_oe  = dq_oe_ff;
    nxt_hsb_oe = hsb_oe_ff;
    nxt_done   = 1'b0;
    nxt_skip   = skip_ff;
    case (state_ff)
      ST_IDLE: begin
        // requests are refused here only by ready_o being low elsewhere
        if (req_i) begin
          nxt_op    = op_i;
          nxt_addr  = addr_i;
          nxt_wdata = wdata_i;
          nxt_step  = 3'h0;
          case (op_i)
            OP_READ: begin
              nxt_ce_n  = 1'b0;                     // see [RULE11]
              nxt_oe_n  = 1'b0;
              nxt_be_n  = be_n_i;                   // see [RULE12]
              nxt_cnt   = CW'(RC_CYC - 1);
              nxt_state = ST_ACC;
            end
            OP_WRITE: begin
              nxt_ce_n  = 1'b0;                     // see [RULE11]
              nxt_we_n  = 1'b0;
              nxt_dq_oe = 1'b1;
              nxt_be_n  = be_n_i;                   // see [RULE13]
              nxt_cnt   = CW'(PWE_CYC - 1);
              nxt_state = ST_ACC;
            end
            OP_STORE, OP_RECALL: begin
              // chip-select and output strobe low, write strobe stays high
              nxt_ce_n  = 1'b0;                     // see [RULE1] see [RULE3]
              nxt_oe_n  = 1'b0;
              nxt_be_n  = 2'b00;
              nxt_addr  = seq_addr(op_i, 3'h0);     // see [RULE2]
              nxt_cnt   = CW'(RC_CYC - 1);          // see [RULE5]
              nxt_state = ST_SEQ;
            end
            OP_HSAVE: begin
              // no access is started until the save resolves
              nxt_hsb_oe = 1'b1;                    // see [RULE7] see [RULE16]
              nxt_cnt    = CW'(PHSB_CYC - 1);
              nxt_state  = ST_HPULSE;
            end
            default: begin
              nxt_done = 1'b1;                      // unknown op completes at once
            end
          endcase
        end
      end
      ST_ACC: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CW'(1);
        end else begin
          // sample at the end of the strobe phase, access time long met
          if (op_ff == OP_READ) begin
            nxt_rdata = lane_mask(dq_i, be_n_ff);   // see [RULE12]
          end
          nxt_ce_n  = 1'b1;
          nxt_we_n  = 1'b1;
          nxt_oe_n  = 1'b1;
          nxt_dq_oe = 1'b0;
          nxt_be_n  = 2'b11;
          nxt_done  = 1'b1;
          nxt_state = ST_GAP;
        end
      end
      ST_GAP: begin
        // one cycle with strobes high keeps address changes outside the strobe
        nxt_state = ST_IDLE;
      end
      ST_SEQ: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CW'(1);
        end else begin
          // command read data is never returned; the sixth may be invalid
          nxt_ce_n  = 1'b1;                         // see [RULE1] see [RULE4]
          nxt_oe_n  = 1'b1;
          nxt_state = ST_SEQGAP;
        end
      end
      ST_SEQGAP: begin
        if (step_ff == SEQ_LAST) begin
          // processing time plus the operation itself
          nxt_be_n  = 2'b11;
          nxt_cnt   = (op_ff == OP_RECALL) ? CW'(SS_WAIT + RECALL_WAIT)   // see [RULE17]
                                           : CW'(SS_WAIT + STORE_WAIT);   // see [RULE8]
          nxt_state = ST_LOCK;                      // see [RULE9]
        end else begin
          nxt_step  = step_ff + 3'h1;
          nxt_addr  = seq_addr(op_ff, step_ff + 3'h1);  // see [RULE2]
          nxt_ce_n  = 1'b0;
          nxt_oe_n  = 1'b0;
          nxt_cnt   = CW'(RC_CYC - 1);              // see [RULE5]
          nxt_state = ST_SEQ;
        end
      end
      ST_HPULSE: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CW'(1);
        end else begin
          // release; the pull-up or the device now sets the wire level
          nxt_hsb_oe = 1'b0;                        // see [RULE10]
          nxt_hbusy  = 1'b0;
          nxt_cnt    = CW'(DHSB_CYC);
          nxt_state  = ST_HWAIT;
        end
      end
      ST_HWAIT: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CW'(1);
        end else if (hw_save_busy_n_i) begin
          // released in time and never seen busy: nothing was saved
          nxt_skip  = ~hbusy_ff;                    // see [RULE6] see [RULE15]
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          // device is holding the wire low while it saves
          nxt_hbusy = 1'b1;                         // see [RULE18]
          nxt_cnt   = CW'(STORE_WAIT);
          nxt_state = ST_LOCK;                      // see [RULE14]
        end
      end
      ST_LOCK: begin
        // a hardware save ends early once the busy wire returns high
        if (cnt_ff == '0 || (op_ff == OP_HSAVE && hw_save_busy_n_i)) begin
          if (op_ff == OP_HSAVE) begin
            nxt_skip = 1'b0;
          end
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - CW'(1);                // see [RULE9] see [RULE14]
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // register everything; strobes reset to inactive
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= '0;
      step_ff   <= 3'h0;
      op_ff     <= OP_READ;
      hbusy_ff  <= 1'b0;
      addr_ff   <= '0;
      wdata_ff  <= '0;
      rdata_ff  <= '0;
      be_n_ff   <= 2'b11;
      ce_n_ff   <= 1'b1;
      we_n_ff   <= 1'b1;
      oe_n_ff   <= 1'b1;
      dq_oe_ff  <= 1'b0;
      hsb_oe_ff <= 1'b0;
      done_ff   <= 1'b0;
      skip_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      step_ff   <= nxt_step;
      op_ff     <= nxt_op;
      hbusy_ff  <= nxt_hbusy;
      addr_ff   <= nxt_addr;
      wdata_ff  <= nxt_wdata;
      rdata_ff  <= nxt_rdata;
      be_n_ff   <= nxt_be_n;
      ce_n_ff   <= nxt_ce_n;
      we_n_ff   <= nxt_we_n;
      oe_n_ff   <= nxt_oe_n;
      dq_oe_ff  <= nxt_dq_oe;
      hsb_oe_ff <= nxt_hsb_oe;
      done_ff   <= nxt_done;
      skip_ff   <= nxt_skip;
    end
  end

  // outputs
  assign ready_o               = (state_ff == ST_IDLE);
  assign done_o                = done_ff;
  assign rdata_o               = rdata_ff;
  assign save_skipped_o        = skip_ff;
  assign mem_addr_o            = addr_ff;
  assign chip_sel_n_o          = ce_n_ff;
  assign write_en_n_o          = we_n_ff;
  assign out_en_n_o            = oe_n_ff;
  assign upper_byte_enable_n_o = be_n_ff[1];
  assign lower_byte_enable_n_o = be_n_ff[0];
  assign dq_o                  = wdata_ff;
  assign dq_oe_o               = dq_oe_ff;
  assign hw_save_busy_n_o      = 1'b0;          // only ever pulls low
  assign hw_save_busy_n_oe_o   = hsb_oe_ff;

endmodule

`default_nettype wire

// File: design/nvs_pkg.sv
// nvs_pkg: constants, op codes and cycle arithmetic for the nv-sram host controller
// assumes a single system clock; all pin timing is derived from its period
`default_nettype none
package nvs_pkg;

  // bus shape
  localparam int unsigned AW = 20;              // address pins
  localparam int unsigned DW = 16;              // data pins, two byte lanes
  localparam int unsigned CW = 18;              // wait counter width

  // clock
  localparam int unsigned CLK_PERIOD_PS = 50000;  // 20 mhz system clock

  // pin timing, slowest speed grade, in printed units
  localparam int unsigned T_RC_NS     = 45;     // read / initiation cycle, least
  localparam int unsigned T_PWE_NS    = 30;     // write pulse width, least
  localparam int unsigned T_PHSB_NS   = 15;     // save request pulse, least
  localparam int unsigned T_DHSB_NS   = 25;     // busy release when nothing to save, most
  localparam int unsigned T_SS_US     = 100;    // command processing time, most
  localparam int unsigned T_RECALL_US = 200;    // restore duration, most
  localparam int unsigned T_STORE_MS  = 8;      // save duration, most

  // whole cycles covering a time in ps, never less than one
  function automatic int unsigned cyc_ceil(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned RC_CYC     = cyc_ceil(T_RC_NS * 1000);
  localparam int unsigned PWE_CYC    = cyc_ceil(T_PWE_NS * 1000);
  localparam int unsigned PHSB_CYC   = cyc_ceil(T_PHSB_NS * 1000);
  localparam int unsigned DHSB_CYC   = cyc_ceil(T_DHSB_NS * 1000);
  localparam int unsigned SS_CYC     = cyc_ceil(T_SS_US * 1000000);
  localparam int unsigned RECALL_CYC = cyc_ceil(T_RECALL_US * 1000000);
  // divide first: milliseconds in ps would overflow 32 bits
  localparam int unsigned STORE_CYC  = T_STORE_MS * (1000000000 / CLK_PERIOD_PS);

  // user commands
  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_WRITE  = 3'h1,
    OP_STORE  = 3'h2,
    OP_RECALL = 3'h3,
    OP_HSAVE  = 3'h4
  } nvs_op_t;

  localparam int unsigned SEQ_LEN  = 6;          // reads in a software command
  localparam logic [2:0]  SEQ_LAST = 3'h5;       // index of the final read

endpackage

`default_nettype wire

// File: design/nvs_host_ctrl_dummy_none.sv
// nvs_host_ctrl_dummy_none: intentionally empty compilation unit
// assumes nothing; holds no logic

// File: dv/nvs_host_ctrl_asserts.sv
// nvs_host_ctrl_asserts: pin protocol checks on the host controller
// assumes default command addresses and one-cycle read and write strobes
`timescale 1ns/10ps
`default_nettype none
module nvs_chk
  import nvs_pkg::*;
(
  // clock, reset and user side
  input wire logic          clk_sys_i,
  input wire logic          resetn_i,
  input wire logic          req_i,
  input wire nvs_op_t       op_i,
  input wire logic [1:0]    be_n_i,
  input wire logic          ready_o,
  input wire logic          done_o,
  // device side
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic          chip_sel_n_o,
  input wire logic          write_en_n_o,
  input wire logic          out_en_n_o,
  input wire logic          upper_byte_enable_n_o,
  input wire logic          lower_byte_enable_n_o,
  input wire logic          dq_oe_o,
  input wire logic          hw_save_busy_n_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // an accepted request of one kind
  sequence s_acc(nvs_op_t o);
    ready_o && req_i && op_i == o;
  endsequence
  // a software command, either kind
  sequence s_cmd;
    ready_o && req_i && (op_i == OP_STORE || op_i == OP_RECALL);
  endsequence
  sequence s_rd_pins;
    !chip_sel_n_o && !out_en_n_o && write_en_n_o;
  endsequence
  property p_read;
    s_acc(OP_READ) |=> s_rd_pins ##1 done_o;
  endproperty
  a_read: assert property (p_read) else $error("read strobes or done misplaced");
  property p_write;
    s_acc(OP_WRITE) |=> (!chip_sel_n_o && !write_en_n_o && dq_oe_o) ##1 done_o;
  endproperty
  a_write: assert property (p_write) else $error("write strobes misplaced");
  property p_lanes;
    s_acc(OP_READ) |=> {upper_byte_enable_n_o, lower_byte_enable_n_o} == $past(be_n_i);
  endproperty
  a_lanes: assert property (p_lanes) else $error("byte enables differ from request");
  property p_we_ce;
    !write_en_n_o |-> !chip_sel_n_o && out_en_n_o;
  endproperty
  a_we_ce: assert property (p_we_ce) else $error("write without select");
  property p_drive;
    dq_oe_o |-> !write_en_n_o;
  endproperty
  a_drive: assert property (p_drive) else $error("data driven outside write");
  property p_idle;
    ready_o |-> chip_sel_n_o;
  endproperty
  a_idle: assert property (p_idle) else $error("selected while idle");
  property p_cmd_we;
    s_cmd |=> write_en_n_o [*8];
  endproperty
  a_cmd_we: assert property (p_cmd_we) else $error("write strobe in command");
  property p_cmd_first;
    s_cmd |=> s_rd_pins and mem_addr_o == 20'h00001;
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("command start wrong");
  property p_lock;
    s_cmd |=> ##13 chip_sel_n_o [*8];
  endproperty
  a_lock: assert property (p_lock) else $error("access during lockout");
  property p_hsb;
    s_acc(OP_HSAVE) |=> hw_save_busy_n_oe_o ##1 !hw_save_busy_n_oe_o;
  endproperty
  a_hsb: assert property (p_hsb) else $error("save pulse wrong");
  property p_hsb_only;
    hw_save_busy_n_oe_o |-> $past(req_i) && $past(op_i) == OP_HSAVE;
  endproperty
  a_hsb_only: assert property (p_hsb_only) else $error("save wire pulled unasked");
  // strobes high between command reads, so each read is one full strobe phase
  sequence s_rd_gap;
    chip_sel_n_o && out_en_n_o && write_en_n_o;
  endsequence
  property p_cmd_step;
    s_cmd |=> s_rd_pins ##1 s_rd_gap ##1 s_rd_pins ##1 s_rd_gap;
  endproperty
  a_cmd_step: assert property (p_cmd_step) else $error("command read phase wrong");
endmodule
bind nvs_host_ctrl nvs_chk u_chk (.clk_sys_i, .resetn_i, .req_i, .op_i, .be_n_i, .ready_o,
  .done_o, .mem_addr_o, .chip_sel_n_o, .write_en_n_o, .out_en_n_o, .upper_byte_enable_n_o,
  .lower_byte_enable_n_o, .dq_oe_o, .hw_save_busy_n_oe_o);
`default_nettype wire

// File: dv/nvs_dev_model.sv
// nvs_dev_model: behavioural nonvolatile sram, sampled on the host clock
// assumes host pins are registered on that clock; only 16 words are kept
`timescale 1ns/10ps
`default_nettype none
module nvs_dev_model
  import nvs_pkg::*;
#(
  parameter int unsigned STORE_T  = 15,  // save time, below the host wait
  parameter int unsigned RECALL_T = 8    // restore time, below the host wait
) (
  // pins as the device sees them
  input  wire logic          clk_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          ce_n_i,
  input  wire logic          we_n_i,
  input  wire logic          oe_n_i,
  input  wire logic          ub_n_i,
  input  wire logic          lb_n_i,
  input  wire logic [DW-1:0] din_i,
  input  wire logic          hsb_i,
  output logic [DW-1:0]      dout_o,
  output logic               busy_o = 1'b0
);
  logic [DW-1:0] mem [16] = '{default: '0};  // array
  logic [DW-1:0] nv [16]  = '{default: '0};  // nonvolatile copy
  logic          dirty    = 1'b0;            // written since last nv cycle
  logic [2:0]    step     = 3'h0;            // command reads matched
  int unsigned   lock     = 0;               // lockout cycles left
  logic [7:0]    junk     = 8'h5a;           // floating lanes change each clock, repeating every 256 cycles
  wire logic [3:0] a      = addr_i[3:0];
  wire logic     rd       = !ce_n_i && we_n_i && !oe_n_i && lock == 0;
  // sixth command read is blanked, as outputs switch off then
  assign dout_o[15:8] = (rd && !ub_n_i && step != 3'h5) ? mem[a][15:8] : junk;
  assign dout_o[7:0]  = (rd && !lb_n_i && step != 3'h5) ? mem[a][7:0] : ~junk;
  // one process: lockout first, then save request, write, read
  always @(posedge clk_i) begin
    junk <= junk + 8'h3b;
    if (lock != 0) begin  // port ignored
      lock <= lock - 1;
      if (lock == 1) busy_o <= 1'b0;
    end else if (!hsb_i && !busy_o) begin
      if (dirty) begin  // clean array: no save, wire left alone
        nv <= mem;
        dirty <= 1'b0;
        busy_o <= 1'b1;
        lock <= STORE_T;
      end
    end else if (!ce_n_i && !we_n_i) begin
      if (!ub_n_i) mem[a][15:8] <= din_i[15:8];
      if (!lb_n_i) mem[a][7:0] <= din_i[7:0];
      dirty <= 1'b1;
      step <= 3'h0;  // a write breaks any command
    end else if (rd) begin  // ordered reads acted on at once
      if (step == 3'h5 && a == 4'h6) begin
        nv <= mem;
        dirty <= 1'b0;
        busy_o <= 1'b1;
        lock <= STORE_T;
        step <= 3'h0;
      end else if (step == 3'h5 && a == 4'h7) begin
        mem <= nv;
        dirty <= 1'b0;
        lock <= RECALL_T;
        step <= 3'h0;
      end else
        step <= (addr_i == AW'(step) + 20'h1) ? step + 3'h1 : 3'(addr_i == 20'h1);
    end
  end
endmodule
`default_nettype wire

// File: dv/nvs_tb.sv
// nvs_tb: self-checking bench for the host controller against the device model
// assumes short lockout waits and a pull-up on the save/busy wire
`timescale 1ns/10ps
`default_nettype none
module testbench
  import nvs_pkg::*;
;
  logic          clk_sys_i = 1'b0;
  logic          resetn_i  = 1'b0;
  logic          req_i     = 1'b0;
  nvs_op_t       op_i      = OP_READ;
  logic [AW-1:0] addr_i    = '0;
  logic [DW-1:0] wdata_i   = '0;
  logic [1:0]    be_n_i    = 2'b00;
  logic          ready_o, done_o, save_skipped_o, chip_sel_n_o, write_en_n_o, out_en_n_o;
  logic          upper_byte_enable_n_o, lower_byte_enable_n_o, dq_oe_o, dev_busy;
  logic          hw_save_busy_n_o, hw_save_busy_n_oe_o;
  logic [DW-1:0] rdata_o, dq_o, dev_dout;
  logic [AW-1:0] mem_addr_o;
  wire  logic [DW-1:0] dq_w = dq_oe_o ? dq_o : dev_dout;  // shared data bus
  wire  logic    hsb_w = ((hw_save_busy_n_oe_o && !hw_save_busy_n_o) || dev_busy) ? 1'b0 : 1'b1;
  int            n_fail = 0;
  int            compares = 0;
  nvs_host_ctrl #(.SS_WAIT(5), .STORE_WAIT(20), .RECALL_WAIT(10)) uut (.clk_sys_i, .resetn_i,
    .req_i, .op_i, .addr_i, .wdata_i, .be_n_i, .ready_o, .done_o, .rdata_o, .save_skipped_o,
    .mem_addr_o, .chip_sel_n_o, .write_en_n_o, .out_en_n_o, .upper_byte_enable_n_o,
    .lower_byte_enable_n_o, .dq_i(dq_w), .dq_o, .dq_oe_o, .hw_save_busy_n_i(hsb_w),
    .hw_save_busy_n_o, .hw_save_busy_n_oe_o);
  nvs_dev_model dev (.clk_i(clk_sys_i), .addr_i(mem_addr_o), .ce_n_i(chip_sel_n_o),
    .we_n_i(write_en_n_o), .oe_n_i(out_en_n_o), .ub_n_i(upper_byte_enable_n_o),
    .lb_n_i(lower_byte_enable_n_o), .din_i(dq_o), .hsb_i(hsb_w), .dout_o(dev_dout),
    .busy_o(dev_busy));
  // compare and count
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request, waits for ready first, then for done within a bound
  task automatic run(input nvs_op_t op, input logic [DW-1:0] d, input logic [1:0] be);
    int n;
    n = 0;
    while (ready_o !== 1'b1) begin
      @(posedge clk_sys_i);
      #1;
    end
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    op_i <= op;
    addr_i <= 20'h00013;
    wdata_i <= d;
    be_n_i <= be;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    #1;
    while (done_o !== 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk({15'h0, done_o}, 16'h0001);
  endtask
  // full word, then every lane pattern on read
  task automatic t_lanes_read;
    run(OP_WRITE, 16'h1234, 2'b00);
    for (int b = 0; b < 4; b++) begin
      run(OP_READ, 16'h0, 2'(b));
      chk(rdata_o, {b[1] ? 8'h00 : 8'h12, b[0] ? 8'h00 : 8'h34});
    end
  endtask
  // single-lane writes leave the other lane alone
  task automatic t_lanes_write;
    run(OP_WRITE, 16'habcd, 2'b10);
    run(OP_READ, 16'h0, 2'b00);
    chk(rdata_o, 16'h12cd);
    run(OP_WRITE, 16'hef00, 2'b01);
    run(OP_READ, 16'h0, 2'b00);
    chk(rdata_o, 16'hefcd);
    // an undefined op completes with done and leaves the read data alone
    run(nvs_op_t'(3'h5), 16'h0, 2'b00);
    chk(rdata_o, 16'hefcd);
  endtask
  // dirty array saves with busy, then a clean one is skipped
  task automatic t_hw_save;
    run(OP_HSAVE, 16'h0, 2'b00);
    chk({15'h0, save_skipped_o}, 16'h0000);
    run(OP_HSAVE, 16'h0, 2'b00);
    chk({15'h0, save_skipped_o}, 16'h0001);
  endtask
  // software save, overwrite, software restore brings saved word back
  task automatic t_sw_cmds;
    run(OP_WRITE, 16'h0f0f, 2'b00);
    run(OP_STORE, 16'h0, 2'b00);
    run(OP_WRITE, 16'h5555, 2'b00);
    run(OP_READ, 16'h0, 2'b00);
    chk(rdata_o, 16'h5555);
    run(OP_RECALL, 16'h0, 2'b00);
    run(OP_READ, 16'h0, 2'b00);
    chk(rdata_o, 16'h0f0f);
    run(OP_HSAVE, 16'h0, 2'b00);
    chk({15'h0, save_skipped_o}, 16'h0001);
  endtask
  // verdict and end of run
  task automatic summarize;
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #25 clk_sys_i = ~clk_sys_i;
  // cuts a hang short; the tests need well under a thousand cycles
  initial begin
    #250000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_lanes_read();
    t_lanes_write();
    t_hw_save();
    t_sw_cmds();
    summarize();
  end
endmodule
`default_nettype wire
